// [hdl/rcfe_front_end.v]
// remote/local control and command line lexer of the remote front end
`timescale 1ns/1ps
`default_nettype none
`include "rcfe_regs.vh"

module rcfe_front_end #(
  parameter BIT_CYC = `RCFE_BIT_CYC,
  parameter DEPTH   = `RCFE_LINE_DEPTH,
  parameter AW      = `RCFE_LINE_AW,
  parameter MARGIN  = `RCFE_FULL_MARGIN
) (
  input  wire       i_core_clk,
  input  wire       i_rst,
  input  wire       i_rxd,
  input  wire       i_key_stb,
  input  wire [7:0] i_key_code,
  input  wire [1:0] i_disp_sel,
  output reg        o_rts,
  output reg        o_remote,
  output reg        o_key_stb,
  output reg  [7:0] o_key_code,
  output reg  [1:0] o_disp_mode,
  output reg        o_tok_valid,
  output reg  [7:0] o_tok_char,
  output reg  [2:0] o_tok_kind,
  output reg        o_cmd_end,
  output reg        o_cmd_query,
  output reg        o_cmd_common,
  output reg  [3:0] o_cmd_levels,
  output reg        o_resp_req,
  output reg        o_line_end,
  output reg        o_overrun
);

  // ****************************************
  // states
  // ****************************************
  localparam [1:0] ST_FILL = 2'b01;  // collecting a line
  localparam [1:0] ST_SCAN = 2'b10;  // walking the stored line

  // ****************************************
  // helpers
  // ****************************************
  // separator between header and parameters
  function is_ws;
    input [7:0] c;
    begin
      is_ws = (c <= `RCFE_CH_SPACE) && (c != `RCFE_CH_LF);  // [RULE_09]
    end
  endfunction

  // fold lower case onto upper case
  function [7:0] to_upper;
    input [7:0] c;
    begin
      if ((c >= `RCFE_CH_LOW_A) && (c <= `RCFE_CH_LOW_Z)) begin
        to_upper = c & ~`RCFE_CASE_BIT;  // [RULE_17]
      end else begin
        to_upper = c;
      end
    end
  endfunction

  // ****************************************
  // declarations
  // ****************************************
  wire          rx_stb;             // byte arrived
  wire [7:0]    rx_data;            // arrived byte
  reg  [7:0]    line_mem [0:DEPTH-1]; // line storage
  reg  [1:0]    state;              // one-hot fsm state
  reg  [AW:0]   wr_cnt;             // bytes stored
  reg  [AW:0]   rd_idx;             // next byte to scan
  reg           in_cmd;             // a command has started
  reg           in_hdr;             // still inside its header
  reg           kw_open;            // a keyword is being read
  reg           cmd_query;          // query mark seen
  reg           cmd_common;         // leading asterisk seen
  reg  [3:0]    cmd_levels;         // keywords counted
  reg           cmd_done;           // command finished this cycle
  wire [7:0]    cur;                // byte under scan
  wire          menu_up;            // release key pressed

  assign cur     = line_mem[rd_idx[AW-1:0]];
  assign menu_up = i_key_stb && (i_key_code == `RCFE_KEY_MENU_UP);

  // ****************************************
  // serial receiver
  // ****************************************
  rcfe_uart_rx #(
    .BIT_CYC (BIT_CYC)
  ) u_rx (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_rxd      (i_rxd),
    .o_stb      (rx_stb),
    .o_data     (rx_data)
  );

  // ****************************************
  // line storage
  // ****************************************
  // plain flops, written only while filling; no reset needed on data
  always @(posedge i_core_clk) begin
    if ((state == ST_FILL) && rx_stb && (rx_data != `RCFE_CH_LF) &&
        (wr_cnt < DEPTH)) begin
      line_mem[wr_cnt[AW-1:0]] <= rx_data;  // [RULE_18]
    end
  end

  // ****************************************
  // flow control
  // ****************************************
  // drop early so bytes already in flight still fit
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rts <= 1'b0;
    end else begin
      o_rts <= (state == ST_FILL) && (wr_cnt < (DEPTH - MARGIN));  // [RULE_19]
    end
  end

  // ****************************************
  // local / remote control
  // ****************************************
  // only the mode flag, panel gate and display mode live here, so switching cannot
  // disturb any stored setting downstream
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_remote    <= 1'b0;  // [RULE_01]
      o_key_stb   <= 1'b0;
      o_key_code  <= 8'h00;
      o_disp_mode <= `RCFE_DISP_LOCAL;
    end else begin
      if (cmd_done) begin
        // a command wins over a release press in the same cycle
        o_remote <= 1'b1;  // [RULE_02] [RULE_06]
      end else if (o_remote && menu_up) begin
        o_remote <= 1'b0;  // [RULE_04] [RULE_06]
      end
      // other keys in remote are swallowed, not a release
      o_key_stb  <= i_key_stb && !o_remote;  // [RULE_03] [RULE_05]
      o_key_code <= i_key_code;
      if (o_remote) begin
        o_disp_mode <= i_disp_sel;  // [RULE_14]
      end else begin
        o_disp_mode <= `RCFE_DISP_LOCAL;
      end
    end
  end

  // ****************************************
  // fill and scan
  // ****************************************
  // bytes arriving during a scan are lost and flagged; the handshake
  // is already low then, so a well behaved controller waits
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state        <= ST_FILL;
      wr_cnt       <= {(AW+1){1'b0}};
      rd_idx       <= {(AW+1){1'b0}};
      in_cmd       <= 1'b0;
      in_hdr       <= 1'b0;
      kw_open      <= 1'b0;
      cmd_query    <= 1'b0;
      cmd_common   <= 1'b0;
      cmd_levels   <= 4'h0;
      cmd_done     <= 1'b0;
      o_tok_valid  <= 1'b0;
      o_tok_char   <= 8'h00;
      o_tok_kind   <= 3'h0;
      o_cmd_end    <= 1'b0;
      o_cmd_query  <= 1'b0;
      o_cmd_common <= 1'b0;
      o_cmd_levels <= 4'h0;
      o_resp_req   <= 1'b0;
      o_line_end   <= 1'b0;
      o_overrun    <= 1'b0;
    end else begin
      o_tok_valid <= 1'b0;
      o_cmd_end   <= 1'b0;
      o_resp_req  <= 1'b0;
      o_line_end  <= 1'b0;
      o_overrun   <= 1'b0;
      cmd_done    <= 1'b0;
      case (state)
        ST_FILL: begin
          if (rx_stb) begin
            if (rx_data == `RCFE_CH_LF) begin
              // line complete: hand it over [RULE_08] [RULE_18]
              state  <= ST_SCAN;
              rd_idx <= {(AW+1){1'b0}};
            end else if (wr_cnt < DEPTH) begin
              wr_cnt <= wr_cnt + 1'b1;
            end else begin
              o_overrun <= 1'b1;  // no room, byte dropped
            end
          end
        end
        ST_SCAN: begin
          if (rx_stb) begin
            o_overrun <= 1'b1;
          end
          if ((rd_idx == wr_cnt) || (cur == `RCFE_CH_SEMI)) begin
            // end of a command at semicolon or at line end [RULE_16]
            if (in_cmd) begin
              o_cmd_end    <= 1'b1;
              o_cmd_query  <= cmd_query;
              o_cmd_common <= cmd_common;
              o_cmd_levels <= cmd_levels;
              o_resp_req   <= cmd_query;  // [RULE_13]
              cmd_done     <= 1'b1;
            end
            in_cmd     <= 1'b0;
            in_hdr     <= 1'b0;
            kw_open    <= 1'b0;
            cmd_query  <= 1'b0;
            cmd_common <= 1'b0;
            cmd_levels <= 4'h0;
            if (rd_idx == wr_cnt) begin
              o_line_end <= 1'b1;
              wr_cnt     <= {(AW+1){1'b0}};
              state      <= ST_FILL;
            end else begin
              rd_idx <= rd_idx + 1'b1;
            end
          end else begin
            rd_idx <= rd_idx + 1'b1;
            if (!in_cmd && is_ws(cur)) begin
              // leading blanks before a header are skipped
            end else if (!in_cmd || in_hdr) begin
              in_cmd <= 1'b1;
              in_hdr <= 1'b1;
              if (is_ws(cur)) begin
                in_hdr <= 1'b0;  // parameters follow [RULE_09] [RULE_12]
              end else if (cur == `RCFE_CH_COLON) begin
                kw_open     <= 1'b0;  // next hierarchy level [RULE_15]
                o_tok_valid <= 1'b1;
                o_tok_char  <= cur;
                o_tok_kind  <= `RCFE_TOK_LEVEL;
              end else if (cur == `RCFE_CH_QUERY) begin
                cmd_query   <= 1'b1;  // mark glued to header [RULE_10]
                o_tok_valid <= 1'b1;
                o_tok_char  <= cur;
                o_tok_kind  <= `RCFE_TOK_QUERY;
              end else begin
                if (!in_cmd && (cur == `RCFE_CH_STAR)) begin
                  cmd_common <= 1'b1;  // [RULE_11]
                end
                if (!kw_open && (cmd_levels != 4'hF)) begin
                  cmd_levels <= cmd_levels + 4'h1;  // [RULE_12] [RULE_15]
                end
                kw_open     <= 1'b1;
                o_tok_valid <= 1'b1;
                o_tok_char  <= to_upper(cur);  // [RULE_17]
                o_tok_kind  <= `RCFE_TOK_KW;
              end
            end else begin
              // parameter bytes pass through unchanged
              o_tok_valid <= 1'b1;
              o_tok_char  <= cur;
              o_tok_kind  <= `RCFE_TOK_PARAM;
            end
          end
        end
        default: begin
          state <= ST_FILL;
        end
      endcase
    end
  end

endmodule // rcfe_front_end
`default_nettype wire

// [hdl/rcfe_regs.vh]
// constants for the remote command front end
// Function
// [RULE_01] power-on starts in manual local state
// [RULE_02] any received command enters remote state
// [RULE_03] remote state blocks front panel key input
// [RULE_04] menu-up key returns device to manual
// [RULE_05] only menu-up key releases, other keys ignored
// [RULE_06] mode switching leaves instrument settings untouched
// [RULE_07] serial framing 9600 baud, 8N1, handshake
// [RULE_08] controller ends each line with linefeed
// [RULE_09] bytes 0-9 and 11-32 are white space
// [RULE_10] header directly followed by '?' is query
// [RULE_11] header starting with '*' is common command
// [RULE_12] headers hold several keywords plus parameters
// [RULE_13] response requested only after a query
// [RULE_14] remote display follows selectable mode
// [RULE_15] colon splits header hierarchy keywords
// [RULE_16] semicolon splits commands within one line
// [RULE_17] keyword letters are matched case-blind
// [RULE_18] whole line buffered until linefeed arrives
// [RULE_19] flow control drops when buffer nearly full
`ifndef RCFE_REGS_VH
`define RCFE_REGS_VH

// ****************************************
// serial timing
// ****************************************
`define RCFE_CLK_HZ      125000000
`define RCFE_BAUD        9600
`define RCFE_BIT_CYC     ((`RCFE_CLK_HZ + (`RCFE_BAUD / 2)) / `RCFE_BAUD)
`define RCFE_DATA_BITS   8

// ****************************************
// line buffer
// ****************************************
`define RCFE_LINE_DEPTH  64
`define RCFE_LINE_AW     6
`define RCFE_FULL_MARGIN 8

// ****************************************
// characters
// ****************************************
`define RCFE_CH_LF       8'h0A
`define RCFE_CH_SPACE    8'h20
`define RCFE_CH_STAR     8'h2A
`define RCFE_CH_COLON    8'h3A
`define RCFE_CH_SEMI     8'h3B
`define RCFE_CH_QUERY    8'h3F
`define RCFE_CH_LOW_A    8'h61
`define RCFE_CH_LOW_Z    8'h7A
`define RCFE_CASE_BIT    8'h20

// ****************************************
// token kinds
// ****************************************
`define RCFE_TOK_KW      3'h1
`define RCFE_TOK_LEVEL   3'h2
`define RCFE_TOK_QUERY   3'h3
`define RCFE_TOK_PARAM   3'h4

// ****************************************
// display modes
// ****************************************
`define RCFE_DISP_BLANK  2'h0
`define RCFE_DISP_CMD    2'h1
`define RCFE_DISP_FULL   2'h2
`define RCFE_DISP_LOCAL  2'h3

// ****************************************
// front panel
// ****************************************
`define RCFE_KEY_MENU_UP 8'h01

`endif

// [hdl/rcfe_uart_rx.v]
// asynchronous serial receiver, 8 data bits, no parity, 1 stop bit
`timescale 1ns/1ps
`default_nettype none
`include "rcfe_regs.vh"

module rcfe_uart_rx #(
  parameter BIT_CYC = `RCFE_BIT_CYC
) (
  input  wire       i_core_clk,
  input  wire       i_rst,
  input  wire       i_rxd,
  output reg        o_stb,
  output reg  [7:0] o_data
);

  // ****************************************
  // pin synchroniser
  // ****************************************
  reg        rxd_meta;   // first stage, read only by rxd_sync
  reg        rxd_sync;   // safe level
  reg [15:0] cyc_cnt;    // cycles within a bit
  reg [3:0]  bit_cnt;    // bit slot in the frame
  reg [7:0]  shift;      // data being assembled
  reg        busy;       // frame in progress

  // two flops before any logic looks at the line
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else begin
      rxd_meta <= i_rxd;
      rxd_sync <= rxd_meta;
    end
  end

  // ****************************************
  // frame sampler
  // ****************************************
  // samples at mid bit; a low stop bit drops the byte as framing error
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cyc_cnt <= 16'h0000;
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
      busy    <= 1'b0;
      o_stb   <= 1'b0;
      o_data  <= 8'h00;
    end else begin
      o_stb <= 1'b0;
      if (!busy) begin
        // start edge: aim first sample at middle of start bit
        if (!rxd_sync) begin
          busy    <= 1'b1;
          bit_cnt <= 4'h0;
          cyc_cnt <= BIT_CYC[16:1];
        end
      end else if (cyc_cnt != 16'h0000) begin
        cyc_cnt <= cyc_cnt - 16'h0001;
      end else begin
        cyc_cnt <= BIT_CYC[15:0] - 16'h0001;
        bit_cnt <= bit_cnt + 4'h1;
        if (bit_cnt == 4'h0) begin
          // glitch on the start bit: give up
          if (rxd_sync) begin
            busy <= 1'b0;
          end
        end else if (bit_cnt <= `RCFE_DATA_BITS) begin
          shift <= {rxd_sync, shift[7:1]};  // lsb first [RULE_07]
        end else begin
          busy <= 1'b0;
          if (rxd_sync) begin
            o_stb  <= 1'b1;  // one stop bit [RULE_07]
            o_data <= shift;
          end
        end
      end
    end
  end

endmodule // rcfe_uart_rx
`default_nettype wire

// [tb/rcfe_ctl_model.sv]
// serial controller model feeding the receive pin
`timescale 1ns/1ps
`default_nettype none
module rcfe_ctl_model #(
  parameter BC = 16                   // cycles per bit
) (
  input  wire logic i_core_clk,
  input  wire logic i_rts,            // high while device takes bytes
  input  wire logic i_obey,           // low only to overrun on purpose
  output var  logic o_txd
);
  initial o_txd = 1'b1;               // mark level between frames
  // one 8N1 frame, lsb first
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    @(posedge i_core_clk);
    while (i_obey && !i_rts) @(posedge i_core_clk); // handshake
    #1;
    for (int i = 0; i < 10; i++) begin
      o_txd = f[i];
      repeat (BC) @(posedge i_core_clk);
      #1;
    end
  endtask
endmodule // rcfe_ctl_model
`default_nettype wire

// [tb/rcfe_properties.sv]
// port assertions of the remote command front end
`timescale 1ns/1ps
`default_nettype none
module rcfe_properties (
  input wire logic       i_core_clk,
  input wire logic       i_rst,
  input wire logic       i_key_stb,
  input wire logic [7:0] i_key_code,
  input wire logic [1:0] i_disp_sel,
  input wire logic       o_remote,
  input wire logic       o_key_stb,
  input wire logic [7:0] o_key_code,
  input wire logic [1:0] o_disp_mode,
  input wire logic       o_tok_valid,
  input wire logic [7:0] o_tok_char,
  input wire logic [2:0] o_tok_kind,
  input wire logic       o_cmd_end,
  input wire logic       o_cmd_query,
  input wire logic       o_resp_req
);
  // one clock domain, so one default for all
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // ****************************************
  // panel keys and remote state
  // ****************************************
  key_fwd_a: assert property (i_key_stb && !o_remote |=> o_key_stb && o_key_code == $past(i_key_code))
    else $error("local key not forwarded");
  key_block_a: assert property (!(i_key_stb && !o_remote) |=> !o_key_stb)
    else $error("key forwarded in remote");
  menu_release_a: assert property (o_remote && i_key_stb && i_key_code == 8'h01 && !o_cmd_end |=> !o_remote)
    else $error("menu-up did not release");
  key_hold_a: assert property (o_remote && !(i_key_stb && i_key_code == 8'h01) |=> o_remote)
    else $error("remote left without menu-up");
  remote_entry_a: assert property (o_cmd_end |=> o_remote)
    else $error("command did not enter remote");
  remote_cause_a: assert property ($rose(o_remote) |-> $past(o_cmd_end))
    else $error("remote without command");
  disp_remote_a: assert property (o_remote |=> o_disp_mode == $past(i_disp_sel))
    else $error("remote display mode wrong");
  disp_local_a: assert property (!o_remote |=> o_disp_mode == 2'h3)
    else $error("local display mode wrong");
  // ****************************************
  // lexer outputs
  // ****************************************
  resp_query_a: assert property (o_resp_req || o_cmd_end |-> o_resp_req == (o_cmd_end && o_cmd_query))
    else $error("response request mismatch");
  kw_upper_a: assert property (o_tok_valid && o_tok_kind == 3'h1 |-> !(o_tok_char inside {[8'h61:8'h7A]}))
    else $error("keyword not upper case");
  kw_space_a: assert property (o_tok_valid && o_tok_kind == 3'h1 |-> o_tok_char > 8'h20)
    else $error("white space in keyword");
  query_tok_a: assert property (o_tok_valid && o_tok_kind == 3'h3 |-> o_tok_char == 8'h3F)
    else $error("query token not question mark");
endmodule // rcfe_properties
bind rcfe_front_end rcfe_properties chk (
  .i_core_clk  (i_core_clk),
  .i_rst       (i_rst),
  .i_key_stb   (i_key_stb),
  .i_key_code  (i_key_code),
  .i_disp_sel  (i_disp_sel),
  .o_remote    (o_remote),
  .o_key_stb   (o_key_stb),
  .o_key_code  (o_key_code),
  .o_disp_mode (o_disp_mode),
  .o_tok_valid (o_tok_valid),
  .o_tok_char  (o_tok_char),
  .o_tok_kind  (o_tok_kind),
  .o_cmd_end   (o_cmd_end),
  .o_cmd_query (o_cmd_query),
  .o_resp_req  (o_resp_req)
);
`default_nettype wire

// [tb/tb.sv]
// self-checking bench of the remote command front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
  logic        i_core_clk, i_rst, i_key_stb, i_rxd, obey;
  logic [7:0]  i_key_code;
  logic [1:0]  i_disp_sel;
  logic        o_rts, o_remote, o_key_stb, o_tok_valid, o_cmd_end, o_cmd_query;
  logic        o_cmd_common, o_resp_req, o_line_end, o_overrun;
  logic [7:0]  o_key_code, o_tok_char;
  logic [1:0]  o_disp_mode;
  logic [2:0]  o_tok_kind;
  logic [3:0]  o_cmd_levels;
  int          fails = 0, num_checks = 0, cyc = 0;
  int          n_line = 0, n_ovr = 0, n_key = 0, n_resp = 0;
  logic [10:0] toks[$];               // kind and byte of each token
  logic [5:0]  cmds[$];               // query, common, levels
  // short bit time keeps the run brief
  rcfe_front_end #(.BIT_CYC(16)) uut (
    .i_core_clk   (i_core_clk),
    .i_rst        (i_rst),
    .i_rxd        (i_rxd),
    .i_key_stb    (i_key_stb),
    .i_key_code   (i_key_code),
    .i_disp_sel   (i_disp_sel),
    .o_rts        (o_rts),
    .o_remote     (o_remote),
    .o_key_stb    (o_key_stb),
    .o_key_code   (o_key_code),
    .o_disp_mode  (o_disp_mode),
    .o_tok_valid  (o_tok_valid),
    .o_tok_char   (o_tok_char),
    .o_tok_kind   (o_tok_kind),
    .o_cmd_end    (o_cmd_end),
    .o_cmd_query  (o_cmd_query),
    .o_cmd_common (o_cmd_common),
    .o_cmd_levels (o_cmd_levels),
    .o_resp_req   (o_resp_req),
    .o_line_end   (o_line_end),
    .o_overrun    (o_overrun)
  );
  rcfe_ctl_model #(.BC(16)) ctl (.i_core_clk(i_core_clk), .i_rts(o_rts), .i_obey(obey), .o_txd(i_rxd));
  // free running core clock, 8 ns period
  initial begin
    i_core_clk = 1'b0;
    forever #4 i_core_clk = ~i_core_clk;
  end
  // ****************************************
  // output monitor and hang guard
  // ****************************************
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (o_tok_valid) toks.push_back({o_tok_kind, o_tok_char});
    if (o_cmd_end) cmds.push_back({o_cmd_query, o_cmd_common, o_cmd_levels});
    n_line <= n_line + o_line_end;
    n_ovr  <= n_ovr + o_overrun;
    n_key  <= n_key + o_key_stb;
    n_resp <= n_resp + o_resp_req;
    if (cyc == 60000) begin
      fails++;
      finish_test();
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic press(logic [7:0] c);
    i_key_stb = 1;
    i_key_code = c;
    tick(1);
    i_key_stb = 0;
    tick(2);
  endtask
  task automatic send_line(string s);
    int n0;
    n0 = n_line;
    for (int i = 0; i < s.len(); i++) ctl.send(s[i]);
    ctl.send(8'h0A);                  // line ends with linefeed
    for (int i = 0; i < 400 && n_line == n0; i++) tick(1);
    `CHK(n_line, n0 + 1)
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    `CHK(o_remote, 1'b0)
    `CHK(o_disp_mode, 2'h3)
    `CHK(o_rts, 1'b1)
    press(8'h05);
    `CHK(n_key, 1)
    `CHK(o_key_code, 8'h05)
    $display("test reset and local keys done");
  endtask
  task t_query;
    toks.delete();
    cmds.delete();
    ctl.send(8'h61);
    ctl.send(8'h3F);
    tick(20);
    `CHK(toks.size(), 0)
    send_line("");
    tick(2);
    `CHK(o_remote, 1'b1)
    `CHK(toks[0], {3'h1, 8'h41})
    `CHK(toks[1], {3'h3, 8'h3F})
    `CHK(cmds[0], {2'b10, 4'h1})
    `CHK(n_resp, 1)
    $display("test query done");
  endtask
  task t_remote_key;
    int k0;
    k0 = n_key;
    for (int d = 0; d < 3; d++) begin
      i_disp_sel = d[1:0];
      tick(2);
      `CHK(o_disp_mode, d[1:0])
    end
    press(8'h05);
    `CHK(o_remote, 1'b1)
    press(8'h01);
    `CHK(o_remote, 1'b0)
    `CHK(n_key, k0)
    `CHK(o_disp_mode, 2'h3)
    $display("test remote keys done");
  endtask
  task t_multi;
    logic [10:0] e [9];
    e = '{11'h12A, 11'h158, 11'h431, 11'h42C, 11'h432, 11'h142, 11'h23A, 11'h143, 11'h464};
    toks.delete();
    cmds.delete();
    send_line(" *x 1,2;B:c\td");
    `CHK(toks.size(), 9)
    for (int i = 0; i < 9; i++) `CHK(toks[i], e[i])
    `CHK(cmds[0], {2'b01, 4'h1})
    `CHK(cmds[1], {2'b00, 4'h2})
    `CHK(n_resp, 1)
    $display("test multi command done");
  endtask
  task t_flow;
    int o0;
    o0 = n_ovr;
    obey = 0;
    for (int i = 0; i < 55; i++) ctl.send(8'h78);
    tick(2);
    `CHK(o_rts, 1'b1)
    ctl.send(8'h78);
    tick(2);
    `CHK(o_rts, 1'b0)
    for (int i = 0; i < 10; i++) ctl.send(8'h78);
    tick(2);
    `CHK(n_ovr, o0 + 2)
    i_rst = 1;
    tick(2);
    i_rst = 0;
    tick(2);
    `CHK(o_rts, 1'b1)
    $display("test flow control done");
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    i_rst      = 1'b1;
    i_key_stb  = 1'b0;
    i_key_code = 8'h00;
    i_disp_sel = 2'h0;
    obey       = 1'b1;
    tick(12);
    i_rst = 0;
    tick(2);
    t_reset;
    t_query;
    t_remote_key;
    t_multi;
    t_flow;
    finish_test;
  end
endmodule // tb
`default_nettype wire
